//--- rtl/cmp_pkg.sv
package cmp_pkg;

  // Bus geometry: every register holds one aligned 32-bit word
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IDX_W  = 10;

  // Register indices; the byte address is four times the index
  localparam logic [IDX_W-1:0] CTRL_IDX       = 10'h019;
  localparam logic [IDX_W-1:0] REF_IDX        = 10'h099;
  localparam logic [IDX_W-1:0] DIR_IDX        = 10'h085;
  localparam logic [IDX_W-1:0] PORT_IDX       = 10'h005;
  localparam logic [IDX_W-1:0] IRQ_STATUS_IDX = 10'h00c;
  localparam logic [IDX_W-1:0] IRQ_SET_IDX    = 10'h00d;
  localparam logic [IDX_W-1:0] IRQ_MASK_IDX   = 10'h08c;

  localparam logic [ADDR_W-1:0] CTRL_ADDR       = {CTRL_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] REF_ADDR        = {REF_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] DIR_ADDR        = {DIR_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] PORT_ADDR       = {PORT_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = {IRQ_STATUS_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] IRQ_SET_ADDR    = {IRQ_SET_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR   = {IRQ_MASK_IDX, 2'b00};

  // Control register fields
  localparam int CTRL_RESULT_BIT = 6;
  localparam int CTRL_INVERT_BIT = 4;
  localparam int CTRL_SWITCH_BIT = 3;
  localparam int MODE_W          = 3;
  localparam int CTRL_STORE_W    = 5;
  localparam logic [CTRL_STORE_W-1:0] CTRL_RESET = 5'h00;

  // Mode codes in which the input switch steers the negative node
  localparam logic [MODE_W-1:0] MODE_SWITCH_A = 3'h6;
  localparam logic [MODE_W-1:0] MODE_SWITCH_B = 3'h5;

  // Reference control fields
  localparam int REF_EN_BIT    = 7;
  localparam int REF_RANGE_BIT = 5;
  localparam int LEVEL_W       = 4;
  localparam logic [7:0] REF_RESET   = 8'h00;
  localparam logic [7:0] REF_WR_MASK = 8'haf;

  // Port pins, direction and the comparator output pin
  localparam int PORT_W      = 6;
  localparam int OUT_PIN_IDX = 2;
  localparam logic [PORT_W-1:0] DIR_RESET  = 6'h3f;
  localparam logic [PORT_W-1:0] PORT_RESET = 6'h00;

  // Interrupt status and mask layout
  localparam int IRQ_EVENT_BIT = 3;
  localparam logic [7:0] IRQ_IMPL_MASK = 8'h08;
  localparam logic [7:0] IRQ_RESET     = 8'h00;

  // Compare node selection codes
  localparam logic [1:0] SEL_POS_PIN = 2'h0;
  localparam logic [1:0] SEL_NEG_PIN = 2'h1;
  localparam logic [1:0] SEL_REF     = 2'h2;
  localparam logic [1:0] SEL_NONE    = 2'h3;

  // Mode table entry: on, drives pin, uses ref, pos sel, neg sel, analog pins
  localparam int ENTRY_W     = 10;
  localparam int E_ON        = 9;
  localparam int E_PIN_OUT   = 8;
  localparam int E_USE_REF   = 7;
  localparam int E_POS_LSB   = 5;
  localparam int E_NEG_LSB   = 3;
  localparam int ANALOG_W    = 3;
  localparam logic [8*ENTRY_W-1:0] MODE_TABLE_DEFAULT = {
    10'b0_0_0_11_11_000,  // 111 comparator off, pins digital
    10'b1_0_1_10_01_011,  // 110 reference vs switched pin
    10'b1_1_1_10_01_011,  // 101 reference vs switched pin, pin out
    10'b1_0_1_10_01_010,  // 100 reference vs negative pin
    10'b1_1_1_10_01_010,  // 011 reference vs negative pin, pin out
    10'b1_0_0_00_01_011,  // 010 two pins
    10'b1_1_0_00_01_011,  // 001 two pins, pin out
    10'b0_0_0_11_11_111   // 000 reset, all analog
  };

  // Bus slave phases
  typedef enum {BUS_IDLE, BUS_ANSWER} bus_state_t;

endpackage

//--- rtl/sync3.sv
`timescale 1ns/1ps
`default_nettype none
module sync3 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Asynchronous level in, filtered level out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] level_reg;
  logic [WIDTH-1:0] level_next;

  // A bit moves only once the second and third stages agree
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      level_next[i] = (s2_reg[i] == s3_reg[i]) ? s2_reg[i] : level_reg[i];
    end
  end

  // First stage feeds only the second to keep metastability contained
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_reg    <= '0;
      s2_reg    <= '0;
      s3_reg    <= '0;
      level_reg <= '0;
    end else begin
      s1_reg    <= async_in;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      level_reg <= level_next;
    end
  end

  assign level_out = level_reg;

endmodule
`default_nettype wire

//--- rtl/mode_lut.sv
`timescale 1ns/1ps
`default_nettype none
module mode_lut #(
  parameter logic [8*cmp_pkg::ENTRY_W-1:0] TABLE = cmp_pkg::MODE_TABLE_DEFAULT
) (
  // Mode code in
  input  wire logic [cmp_pkg::MODE_W-1:0]   mode,
  // Decoded routing
  output logic                              comp_on,
  output logic                              pin_out,
  output logic                              use_ref,
  output logic      [1:0]                   pos_sel,
  output logic      [1:0]                   neg_sel,
  output logic      [cmp_pkg::ANALOG_W-1:0] analog_pins
);

  logic [cmp_pkg::ENTRY_W-1:0] entry;

  // Table is a parameter so a part variant can remap modes without RTL edits
  always_comb begin
    entry       = TABLE[mode*cmp_pkg::ENTRY_W +: cmp_pkg::ENTRY_W];
    comp_on     = entry[cmp_pkg::E_ON];
    pin_out     = entry[cmp_pkg::E_PIN_OUT];
    use_ref     = entry[cmp_pkg::E_USE_REF];
    pos_sel     = entry[cmp_pkg::E_POS_LSB +: 2];
    neg_sel     = entry[cmp_pkg::E_NEG_LSB +: 2];
    analog_pins = entry[cmp_pkg::ANALOG_W-1:0];
  end

endmodule
`default_nettype wire

//--- rtl/comparator_control_logic.sv
// What this block does
// - Raw result is high when positive node exceeds negative node, else low.
// - Software result bit equals raw result forced low in modes 000 and 111, complemented when invert bit set.
// - Result bit sits at control bit 6, read-only, writes ignored.
// - Mode field is three bits at control bits 2 to 0, eight modes.
// - In modes 110 and 101 the switch bit picks the negative node source.
// - Output-capable modes drive the result onto the pin unsynchronised.
// - In output modes the pin direction bit acts as the pin driver enable.
// - Port data reads return zero for every pin configured as analog.
// - Internal reference feeds a comparator input in four modes only.
// - Reference has range bit and 4-bit level code; range set means low range.
// - Result change sets the event flag; software clears it or sets it by hand.
// - Any control register access ends the mismatch so the flag can clear.
// - Reset forces mode 000 and switches the reference off.
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module comparator_control_logic #(
  parameter logic [8*cmp_pkg::ENTRY_W-1:0] MODE_TABLE = cmp_pkg::MODE_TABLE_DEFAULT
) (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // Avalon-MM slave
  input  wire logic [cmp_pkg::ADDR_W-1:0]    avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [cmp_pkg::DATA_W-1:0]    avs_writedata,
  input  wire logic [3:0]                    avs_byteenable,
  output logic      [cmp_pkg::DATA_W-1:0]    avs_readdata,
  output logic                               avs_waitrequest,
  // Analog comparator core and reference ladder
  input  wire logic                          compare_raw_in,
  output logic                               comparator_enable,
  output logic      [1:0]                    positive_compare_node_sel,
  output logic      [1:0]                    negative_compare_node_sel,
  output logic                               reference_enable,
  output logic                               reference_range_bit,
  output logic      [cmp_pkg::LEVEL_W-1:0]   reference_level_code,
  // Port pins and comparator output pin
  input  wire logic [cmp_pkg::PORT_W-1:0]    port_pins_in,
  output logic                               compare_output_pin_out,
  output logic                               compare_output_pin_oe_n,
  // Interrupt
  output logic                               irq
);

  // Register state
  logic [cmp_pkg::CTRL_STORE_W-1:0] ctrl_reg;
  logic [cmp_pkg::CTRL_STORE_W-1:0] ctrl_next;
  logic [7:0]                       ref_reg;
  logic [7:0]                       ref_next;
  logic [cmp_pkg::PORT_W-1:0]       dir_reg;
  logic [cmp_pkg::PORT_W-1:0]       dir_next;
  logic [cmp_pkg::PORT_W-1:0]       port_latch_reg;
  logic [cmp_pkg::PORT_W-1:0]       port_latch_next;
  logic [7:0]                       status_reg;
  logic [7:0]                       status_next;
  logic [7:0]                       mask_reg;
  logic [7:0]                       mask_next;

  // Bus slave state
  cmp_pkg::bus_state_t              bus_state_reg;
  cmp_pkg::bus_state_t              bus_state_next;
  logic [cmp_pkg::DATA_W-1:0]       rdata_reg;
  logic [cmp_pkg::DATA_W-1:0]       rdata_next;
  logic                             wait_reg;
  logic                             wait_next;

  // Comparator result state
  logic                             result_reg;
  logic                             result_next;
  logic                             seen_reg;
  logic                             seen_next;

  // Registered outputs toward the analog side, the pin and the interrupt line
  logic                             comp_on_reg;
  logic                             comp_on_next;
  logic [1:0]                       pos_sel_reg;
  logic [1:0]                       pos_sel_next;
  logic [1:0]                       neg_sel_reg;
  logic [1:0]                       neg_sel_next;
  logic                             ref_en_reg;
  logic                             ref_en_next;
  logic                             pin_mode_reg;
  logic                             pin_mode_next;
  logic                             oe_n_reg;
  logic                             oe_n_next;
  logic                             irq_reg;
  logic                             irq_next;

  // Wires
  logic                             raw_sync;
  logic [cmp_pkg::PORT_W-1:0]       pins_sync;
  logic                             lut_on;
  logic                             lut_pin_out;
  logic                             lut_use_ref;
  logic [1:0]                       lut_pos_sel;
  logic [1:0]                       lut_neg_sel;
  logic [cmp_pkg::ANALOG_W-1:0]     lut_analog;
  logic                             do_access;
  logic                             do_write;
  logic                             wr_lane;
  logic [7:0]                       wbyte;
  logic [cmp_pkg::MODE_W-1:0]       mode;
  logic [cmp_pkg::PORT_W-1:0]       analog_mask;

  // Comparator result and port pins come from another domain
  sync3 #(.WIDTH(1)) u_raw_sync (
    .clk       (clk),
    .rst       (rst),
    .async_in  (compare_raw_in),
    .level_out (raw_sync)
  );

  sync3 #(.WIDTH(cmp_pkg::PORT_W)) u_pin_sync (
    .clk       (clk),
    .rst       (rst),
    .async_in  (port_pins_in),
    .level_out (pins_sync)
  );

  // Mode decode
  mode_lut #(.TABLE(MODE_TABLE)) u_mode_lut (
    .mode        (mode),
    .comp_on     (lut_on),
    .pin_out     (lut_pin_out),
    .use_ref     (lut_use_ref),
    .pos_sel     (lut_pos_sel),
    .neg_sel     (lut_neg_sel),
    .analog_pins (lut_analog)
  );

  // Common decode terms; a request completes on the edge where wait is low
  assign mode        = ctrl_reg[cmp_pkg::MODE_W-1:0];
  assign do_access   = (avs_read | avs_write) & ~wait_reg;
  assign do_write    = avs_write & ~wait_reg;
  assign wr_lane     = avs_byteenable[0];
  assign wbyte       = avs_writedata[7:0];
  assign analog_mask = {{(cmp_pkg::PORT_W-cmp_pkg::ANALOG_W){1'b0}}, lut_analog};

  // Bus handshake: one wait state, then the answer
  always_comb begin
    bus_state_next = bus_state_reg;
    wait_next      = 1'b1;
    rdata_next     = rdata_reg;
    case (bus_state_reg)
      cmp_pkg::BUS_IDLE: begin
        if (avs_read | avs_write) begin
          bus_state_next = cmp_pkg::BUS_ANSWER;
          wait_next      = 1'b0;
          rdata_next     = '0;
          if (!avs_read) begin
            rdata_next = '0;
          end else if (avs_address == cmp_pkg::CTRL_ADDR) begin
            rdata_next[7:0] = {1'b0, result_reg, 1'b0, ctrl_reg};
          end else if (avs_address == cmp_pkg::REF_ADDR) begin
            rdata_next[7:0] = ref_reg;
          end else if (avs_address == cmp_pkg::DIR_ADDR) begin
            rdata_next[cmp_pkg::PORT_W-1:0] = dir_reg;
          end else if (avs_address == cmp_pkg::PORT_ADDR) begin
            rdata_next[cmp_pkg::PORT_W-1:0] = pins_sync & ~analog_mask;
          end else if (avs_address == cmp_pkg::IRQ_STATUS_ADDR) begin
            rdata_next[7:0] = status_reg;
          end else if (avs_address == cmp_pkg::IRQ_MASK_ADDR) begin
            rdata_next[7:0] = mask_reg;
          end else begin
            rdata_next = '0;
          end
        end
      end
      cmp_pkg::BUS_ANSWER: begin
        bus_state_next = cmp_pkg::BUS_IDLE;
      end
      default: begin
        bus_state_next = cmp_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_state_reg <= cmp_pkg::BUS_IDLE;
      wait_reg      <= 1'b1;
      rdata_reg     <= '0;
    end else begin
      bus_state_reg <= bus_state_next;
      wait_reg      <= wait_next;
      rdata_reg     <= rdata_next;
    end
  end

  // Software registers; writes land only on the completing edge, low lane
  always_comb begin
    ctrl_next       = ctrl_reg;
    ref_next        = ref_reg;
    dir_next        = dir_reg;
    port_latch_next = port_latch_reg;
    mask_next       = mask_reg;
    if (do_write && wr_lane) begin
      if (avs_address == cmp_pkg::CTRL_ADDR) begin
        ctrl_next = wbyte[cmp_pkg::CTRL_STORE_W-1:0];
      end else if (avs_address == cmp_pkg::REF_ADDR) begin
        ref_next = wbyte & cmp_pkg::REF_WR_MASK;
      end else if (avs_address == cmp_pkg::DIR_ADDR) begin
        dir_next = wbyte[cmp_pkg::PORT_W-1:0];
      end else if (avs_address == cmp_pkg::PORT_ADDR) begin
        port_latch_next = wbyte[cmp_pkg::PORT_W-1:0];
      end else if (avs_address == cmp_pkg::IRQ_MASK_ADDR) begin
        mask_next = wbyte & cmp_pkg::IRQ_IMPL_MASK;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg       <= cmp_pkg::CTRL_RESET;
      ref_reg        <= cmp_pkg::REF_RESET;
      dir_reg        <= cmp_pkg::DIR_RESET;
      port_latch_reg <= cmp_pkg::PORT_RESET;
      mask_reg       <= cmp_pkg::IRQ_RESET;
    end else begin
      ctrl_reg       <= ctrl_next;
      ref_reg        <= ref_next;
      dir_reg        <= dir_next;
      port_latch_reg <= port_latch_next;
      mask_reg       <= mask_next;
    end
  end

  // Result bit, mismatch tracking and the sticky event flag.
  // A change caught in the same edge as a clear still sets the flag.
  always_comb begin
    // Core reports high when the positive node is above the negative one
    result_next = (lut_on & raw_sync) ^ ctrl_reg[cmp_pkg::CTRL_INVERT_BIT];
    seen_next   = seen_reg;
    if (do_access && avs_address == cmp_pkg::CTRL_ADDR) begin
      seen_next = result_reg;
    end
    status_next = status_reg;
    if (do_write && wr_lane && avs_address == cmp_pkg::IRQ_STATUS_ADDR) begin
      status_next = status_reg & ~(wbyte & cmp_pkg::IRQ_IMPL_MASK);
    end
    if (do_write && wr_lane && avs_address == cmp_pkg::IRQ_SET_ADDR) begin
      status_next = status_next | (wbyte & cmp_pkg::IRQ_IMPL_MASK);
    end
    if (result_reg != seen_reg) begin
      status_next[cmp_pkg::IRQ_EVENT_BIT] = 1'b1;
    end
    irq_next = |(status_reg & mask_reg);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result_reg <= 1'b0;
      seen_reg   <= 1'b0;
      status_reg <= cmp_pkg::IRQ_RESET;
      irq_reg    <= 1'b0;
    end else begin
      result_reg <= result_next;
      seen_reg   <= seen_next;
      status_reg <= status_next;
      irq_reg    <= irq_next;
    end
  end

  // Routing toward the analog core and the pin driver
  always_comb begin
    comp_on_next  = lut_on;
    pos_sel_next  = lut_pos_sel;
    neg_sel_next  = lut_neg_sel;
    if (mode == cmp_pkg::MODE_SWITCH_A || mode == cmp_pkg::MODE_SWITCH_B) begin
      neg_sel_next = ctrl_reg[cmp_pkg::CTRL_SWITCH_BIT] ?
                     cmp_pkg::SEL_POS_PIN : cmp_pkg::SEL_NEG_PIN;
    end
    // Ladder powers up only when enabled and the mode consumes it
    ref_en_next   = ref_reg[cmp_pkg::REF_EN_BIT] & lut_use_ref;
    pin_mode_next = lut_pin_out;
    // Direction bit clear enables the driver; analog pins never drive
    oe_n_next     = dir_reg[cmp_pkg::OUT_PIN_IDX] |
                    analog_mask[cmp_pkg::OUT_PIN_IDX];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      comp_on_reg  <= 1'b0;
      pos_sel_reg  <= cmp_pkg::SEL_NONE;
      neg_sel_reg  <= cmp_pkg::SEL_NONE;
      ref_en_reg   <= 1'b0;
      pin_mode_reg <= 1'b0;
      oe_n_reg     <= 1'b1;
    end else begin
      comp_on_reg  <= comp_on_next;
      pos_sel_reg  <= pos_sel_next;
      neg_sel_reg  <= neg_sel_next;
      ref_en_reg   <= ref_en_next;
      pin_mode_reg <= pin_mode_next;
      oe_n_reg     <= oe_n_next;
    end
  end

  // Outputs
  assign avs_readdata              = rdata_reg;
  assign avs_waitrequest           = wait_reg;
  assign comparator_enable         = comp_on_reg;
  assign positive_compare_node_sel = pos_sel_reg;
  assign negative_compare_node_sel = neg_sel_reg;
  assign reference_enable          = ref_en_reg;
  assign reference_range_bit       = ref_reg[cmp_pkg::REF_RANGE_BIT];
  assign reference_level_code      = ref_reg[cmp_pkg::LEVEL_W-1:0];
  assign compare_output_pin_oe_n   = oe_n_reg;
  assign irq                       = irq_reg;

  // Pin path bypasses the synchroniser so the pin follows the core with
  // only gate delay; the price is that it may glitch near the threshold
  assign compare_output_pin_out = pin_mode_reg ?
         ((comp_on_reg & compare_raw_in) ^ ctrl_reg[cmp_pkg::CTRL_INVERT_BIT]) :
         port_latch_reg[cmp_pkg::OUT_PIN_IDX];

endmodule
`default_nettype wire

//--- tb/cmp_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module cmp_ctrl_assertions (
  // Clock, reset and bus
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [11:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Analog side and pin
  input wire logic        comparator_enable,
  input wire logic [1:0]  positive_compare_node_sel,
  input wire logic [1:0]  negative_compare_node_sel,
  input wire logic        reference_enable,
  input wire logic        reference_range_bit,
  input wire logic [3:0]  reference_level_code,
  input wire logic        compare_output_pin_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Completed bus access
  wire logic done = (avs_read | avs_write) & ~avs_waitrequest;

  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer missing");
  a_answer_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer too long");
  a_upper_zero: assert property (!avs_waitrequest && avs_read |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_ctrl_layout: assert property (avs_read && !avs_waitrequest && avs_address == cmp_pkg::CTRL_ADDR |-> avs_readdata[7] == 1'b0 && avs_readdata[5] == 1'b0)
    else $error("unused control bits set");
  a_ref_needs_on: assert property (reference_enable |-> comparator_enable && positive_compare_node_sel == cmp_pkg::SEL_REF)
    else $error("reference on outside a reference mode");
  a_off_no_route: assert property (!comparator_enable |-> positive_compare_node_sel == cmp_pkg::SEL_NONE && negative_compare_node_sel == cmp_pkg::SEL_NONE)
    else $error("routed while off");
  a_neg_never_ref: assert property (negative_compare_node_sel != cmp_pkg::SEL_REF)
    else $error("negative node on reference");
  a_ref_by_write: assert property ($changed({reference_range_bit, reference_level_code}) |-> $past(done) || $past(done, 2))
    else $error("reference code moved without a write");
  a_oe_by_write: assert property ($changed(compare_output_pin_oe_n) |-> $past(done) || $past(done, 2))
    else $error("pin enable moved without a write");
endmodule
bind comparator_control_logic cmp_ctrl_assertions u_chk (
  .clk, .rst, .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
  .comparator_enable, .positive_compare_node_sel, .negative_compare_node_sel,
  .reference_enable, .reference_range_bit, .reference_level_code, .compare_output_pin_oe_n);
`default_nettype wire

//--- tb/analog_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module analog_core_model (
  // Routing from the block
  input wire logic [1:0] pos_sel,
  input wire logic [1:0] neg_sel,
  input wire logic       ref_on,
  input wire logic       range_low,
  input wire logic [3:0] level,
  // Pin levels, 0 to 255 spans ground to supply
  input wire logic [7:0] pin_pos,
  input wire logic [7:0] pin_neg,
  output logic           raw
);
  int ref_lvl;
  int vp;
  int vn;
  function automatic int node(input logic [1:0] s, input int p, input int n, input int r);
    if (s == cmp_pkg::SEL_POS_PIN) return p;
    if (s == cmp_pkg::SEL_NEG_PIN) return n;
    if (s == cmp_pkg::SEL_REF) return r;
    return -1; // Floating node never wins
  endfunction
  // Ladder and comparison settle at once; real response time is not modelled
  always_comb begin
    ref_lvl = range_low ? int'(level) * 256 / 24 : 64 + int'(level) * 8;
    if (!ref_on) ref_lvl = 0;
    vp = node(pos_sel, pin_pos, pin_neg, ref_lvl);
    vn = node(neg_sel, pin_pos, pin_neg, ref_lvl);
    raw = vp > vn;
  end
endmodule
`default_nettype wire

//--- tb/comparator_control_logic_tb.sv
`timescale 1ns/1ps
`default_nettype none
module comparator_control_logic_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] avs_address = 12'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, raw, comparator_enable, reference_enable, reference_range_bit;
  logic [1:0] positive_compare_node_sel, negative_compare_node_sel;
  logic [3:0] reference_level_code;
  logic compare_output_pin_out, compare_output_pin_oe_n, irq;
  logic [7:0] pin_pos = 8'h00;
  logic [7:0] pin_neg = 8'h00;
  logic [5:0] port_pins_in = 6'h00;
  logic [7:0] q, r;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  int p, n;

  always #2 clk = ~clk;

  comparator_control_logic DUT (.clk, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .compare_raw_in(raw),
    .comparator_enable, .positive_compare_node_sel, .negative_compare_node_sel,
    .reference_enable, .reference_range_bit, .reference_level_code, .port_pins_in,
    .compare_output_pin_out, .compare_output_pin_oe_n, .irq);
  analog_core_model core (.pos_sel(positive_compare_node_sel),
    .neg_sel(negative_compare_node_sel), .ref_on(reference_enable),
    .range_low(reference_range_bit), .level(reference_level_code), .pin_pos(pin_pos),
    .pin_neg(pin_neg), .raw(raw));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk(q, exp);
  endtask
  task automatic settle(input int k);
    repeat (k) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  function automatic logic res(input int a, input int b, input logic inv);
    return (a > b) ^ inv;
  endfunction

  // A hang counts as a mismatch
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      complete_run();
    end
  end

  initial begin
    void'($urandom(32'h273e));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(cmp_pkg::CTRL_ADDR, 8'h00);
    rd(cmp_pkg::REF_ADDR, 8'h00);
    rd(cmp_pkg::DIR_ADDR, 8'h3f);
    rd(cmp_pkg::IRQ_STATUS_ADDR, 8'h00);
    rd(12'hffc, 8'h00);
    bus(1'b1, cmp_pkg::CTRL_ADDR, 8'hff);
    rd(cmp_pkg::CTRL_ADDR, 8'h5f);
    // Every mode
    for (int m = 0; m < 8; m++) begin
      bus(1'b1, cmp_pkg::REF_ADDR, 8'h80);
      bus(1'b1, cmp_pkg::CTRL_ADDR, 8'(m));
      settle(2);
      chk(reference_enable, m >= 3 && m <= 6);
      chk(comparator_enable, m != 0 && m != 7);
    end
    // Input switch in both switched modes
    for (int m = 5; m < 7; m++) for (int s = 0; s < 2; s++) begin
      bus(1'b1, cmp_pkg::CTRL_ADDR, 8'(s * 8 + m));
      settle(2);
      chk(negative_compare_node_sel, s ? cmp_pkg::SEL_POS_PIN : cmp_pkg::SEL_NEG_PIN);
    end
    repeat (4) begin
      r = 8'($urandom);
      bus(1'b1, cmp_pkg::REF_ADDR, r);
      rd(cmp_pkg::REF_ADDR, r & cmp_pkg::REF_WR_MASK);
      chk({reference_range_bit, reference_level_code}, {r[5], r[3:0]});
    end
    // Random pin levels, both polarities
    for (int i = 0; i < 8; i++) begin
      p = $urandom_range(255);
      n = (p + 1 + $urandom_range(253)) % 256;
      pin_pos <= 8'(p);
      pin_neg <= 8'(n);
      bus(1'b1, cmp_pkg::CTRL_ADDR, 8'(i % 2 * 16 + 2));
      settle(12);
      rd(cmp_pkg::CTRL_ADDR, {1'b0, res(p, n, i % 2), 1'b0, 1'(i % 2), 4'h2});
    end
    // Pin follows raw result within one cycle
    bus(1'b1, cmp_pkg::DIR_ADDR, 8'h3b);
    bus(1'b1, cmp_pkg::CTRL_ADDR, 8'h01);
    settle(2);
    chk(compare_output_pin_oe_n, 1'b0);
    pin_pos <= 8'h90;
    pin_neg <= 8'h10;
    @(negedge clk);
    chk(compare_output_pin_out, 1'b1);
    pin_pos <= 8'h10;
    pin_neg <= 8'h90;
    @(negedge clk);
    chk(compare_output_pin_out, 1'b0);
    bus(1'b1, cmp_pkg::CTRL_ADDR, 8'h11);
    settle(2);
    chk(compare_output_pin_out, 1'b1);
    bus(1'b1, cmp_pkg::DIR_ADDR, 8'h3f);
    settle(2);
    chk(compare_output_pin_oe_n, 1'b1);
    // Analog pins read as zero
    port_pins_in <= 6'($urandom);
    bus(1'b1, cmp_pkg::CTRL_ADDR, 8'h00);
    settle(4);
    rd(cmp_pkg::PORT_ADDR, {2'b00, port_pins_in & 6'h38});
    bus(1'b1, cmp_pkg::CTRL_ADDR, 8'h07);
    settle(4);
    rd(cmp_pkg::PORT_ADDR, {2'b00, port_pins_in});
    // Event flag, mismatch, clear, set
    bus(1'b1, cmp_pkg::CTRL_ADDR, 8'h02);
    bus(1'b1, cmp_pkg::IRQ_MASK_ADDR, 8'h08);
    pin_pos <= 8'h80;
    pin_neg <= 8'h20;
    settle(12);
    rd(cmp_pkg::IRQ_STATUS_ADDR, 8'h08);
    chk(irq, 1'b1);
    bus(1'b1, cmp_pkg::IRQ_STATUS_ADDR, 8'h08);
    rd(cmp_pkg::IRQ_STATUS_ADDR, 8'h08);
    rd(cmp_pkg::CTRL_ADDR, 8'h42);
    bus(1'b1, cmp_pkg::IRQ_STATUS_ADDR, 8'h08);
    rd(cmp_pkg::IRQ_STATUS_ADDR, 8'h00);
    settle(1);
    chk(irq, 1'b0);
    bus(1'b1, cmp_pkg::IRQ_SET_ADDR, 8'h08);
    settle(1);
    chk(irq, 1'b1);
    bus(1'b1, cmp_pkg::IRQ_MASK_ADDR, 8'h00);
    settle(1);
    chk(irq, 1'b0);
    // Reset in mid-run
    bus(1'b1, cmp_pkg::REF_ADDR, 8'h80);
    bus(1'b1, cmp_pkg::CTRL_ADDR, 8'h03);
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    settle(1);
    chk(reference_enable, 1'b0);
    rd(cmp_pkg::CTRL_ADDR, 8'h00);
    rd(cmp_pkg::REF_ADDR, 8'h00);
    complete_run();
  end
endmodule
`default_nettype wire
